// [pkg/lane_cond_pkg.sv]
// Constants, types and register map for the lane conditioning register bank
package lane_cond_pkg;

    // ********************************************************************
    // Register offsets
    // ********************************************************************
    localparam logic [7:0] ADDR_L2_IDLE_THR  = 8'h20;
    localparam logic [7:0] ADDR_RSVD_21      = 8'h21;
    localparam logic [7:0] ADDR_L3_SIG_DET   = 8'h22;
    localparam logic [7:0] ADDR_L3_IDLE_PRES = 8'h23;
    localparam logic [7:0] ADDR_L3_EQ        = 8'h24;
    localparam logic [7:0] ADDR_L3_SWING     = 8'h25;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [7:0] RST_L2_IDLE_THR  = 8'h00;
    localparam logic [7:0] RST_RSVD_21      = 8'h00;
    localparam logic [7:0] RST_L3_SIG_DET   = 8'h00;
    localparam logic [7:0] RST_L3_IDLE_PRES = 8'h00;
    localparam logic [7:0] RST_L3_EQ        = 8'h2F;
    localparam logic [7:0] RST_L3_SWING     = 8'hAD;
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int THR_ASSERT_LSB   = 2;
    localparam int THR_DEASSERT_LSB = 0;
    localparam int SD_FORCE_OFF_BIT = 2;
    localparam int SD_FORCE_ON_BIT  = 1;
    localparam int IDLE_OVR_BIT     = 5;
    localparam int MUTE_SEL_BIT     = 4;
    localparam int PRES_MODE_LSB    = 2;
    localparam int SHORT_PROT_BIT   = 7;
    localparam int GEN_SEL_BIT      = 6;
    localparam int SWING_LSB        = 0;
    localparam int SWING_RSVD_LSB   = 3;
    localparam logic [2:0] SWING_RSVD_PATTERN = 3'h5;

    // ********************************************************************
    // Threshold and swing tables, millivolts
    // ********************************************************************
    localparam logic [7:0] ASSERT_MV   [4] = '{8'hB4, 8'hA0, 8'hD2, 8'hBE};
    localparam logic [7:0] DEASSERT_MV [4] = '{8'h6E, 8'h64, 8'h96, 8'h82};
    localparam logic [10:0] SWING_BASE_MV = 11'h2BC;
    localparam logic [10:0] SWING_STEP_MV = 11'h064;

    // ********************************************************************
    // Presence-detect modes and timing
    // ********************************************************************
    localparam logic [1:0] PRES_HIZ     = 2'h0;
    localparam logic [1:0] PRES_LIMITED = 2'h1;
    localparam logic [1:0] PRES_FOREVER = 2'h2;
    localparam logic [1:0] PRES_TERM    = 2'h3;
    localparam int PROBE_PERIOD_MS = 12;
    localparam int CLK_RATE_KHZ    = 200000;
    localparam int PROBE_CYCLES    = PROBE_PERIOD_MS * CLK_RATE_KHZ;
    localparam int PROBE_ATTEMPTS  = 50;

    typedef enum logic [3:0] {
        PD_OFF    = 4'b0001,
        PD_PROBE  = 4'b0010,
        PD_FOUND  = 4'b0100,
        PD_GIVEUP = 4'b1000
    } pd_state_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

endpackage : lane_cond_pkg

// [logic/lane_signal_conditioning_regs.sv]
// Lane conditioning register bank with presence-detect sequencer
`timescale 1ns/1ps

module lane_signal_conditioning_regs #(
    parameter int PROBE_CYCLES   = lane_cond_pkg::PROBE_CYCLES,
    parameter int PROBE_ATTEMPTS = lane_cond_pkg::PROBE_ATTEMPTS
) (
    input  wire logic                       mclk_in,
    input  wire logic                       rst_in,
    input  wire lane_cond_pkg::reg_req_type reg_req_in,
    output logic [7:0]                      reg_rdata_out,
    output logic                            reg_rvalid_out,
    output logic [7:0]                      lane2_assert_mv_out,
    output logic [7:0]                      lane2_deassert_mv_out,
    input  wire logic                       lane3_sig_det_raw_in,
    output logic                            lane3_sig_det_out,
    input  wire logic                       lane3_auto_idle_in,
    output logic                            lane3_mute_out,
    input  wire logic                       lane3_receiver_seen_in,
    output logic                            lane3_probe_out,
    output logic                            lane3_term_50_out,
    output logic                            lane3_presence_found_out,
    output logic [7:0]                      lane3_eq_level_out,
    output logic                            lane3_short_prot_out,
    output logic                            lane3_gen12_out,
    output logic [2:0]                      lane3_swing_code_out,
    output logic [10:0]                     lane3_swing_mv_out
);

    localparam int TW = $clog2(PROBE_CYCLES + 1);
    localparam int AW = $clog2(PROBE_ATTEMPTS + 1);
    localparam logic [TW-1:0] TIMER_LAST = TW'(PROBE_CYCLES - 1);
    localparam logic [AW-1:0] ATT_LIMIT  = AW'(PROBE_ATTEMPTS);
    localparam logic [TW-1:0] GAP_MAX    = TW'(PROBE_CYCLES);

    // ********************************************************************
    // Register file
    // ********************************************************************
    logic [7:0] thr_q;
    logic [7:0] rsvd_q;
    logic [7:0] sigdet_q;
    logic [7:0] idle_q;
    logic [7:0] eq_q;
    logic [7:0] swing_q;

    wire hit_thr   = reg_req_in.addr == lane_cond_pkg::ADDR_L2_IDLE_THR;
    wire hit_rsvd  = reg_req_in.addr == lane_cond_pkg::ADDR_RSVD_21;
    wire hit_sd    = reg_req_in.addr == lane_cond_pkg::ADDR_L3_SIG_DET;
    wire hit_idle  = reg_req_in.addr == lane_cond_pkg::ADDR_L3_IDLE_PRES;
    wire hit_eq    = reg_req_in.addr == lane_cond_pkg::ADDR_L3_EQ;
    wire hit_swing = reg_req_in.addr == lane_cond_pkg::ADDR_L3_SWING;

    logic [7:0] rmux;
    always_comb begin
        rmux = lane_cond_pkg::READ_UNMAPPED;
        if (hit_thr)   rmux = thr_q;
        if (hit_rsvd)  rmux = rsvd_q;
        if (hit_sd)    rmux = sigdet_q;
        if (hit_idle)  rmux = idle_q;
        if (hit_eq)    rmux = eq_q;
        if (hit_swing) rmux = swing_q;
    end

    // Reserved bits are stored as written; software keeps them at default
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            thr_q    <= lane_cond_pkg::RST_L2_IDLE_THR;
            rsvd_q   <= lane_cond_pkg::RST_RSVD_21;
            sigdet_q <= lane_cond_pkg::RST_L3_SIG_DET;
            idle_q   <= lane_cond_pkg::RST_L3_IDLE_PRES;
            eq_q     <= lane_cond_pkg::RST_L3_EQ;
            swing_q  <= lane_cond_pkg::RST_L3_SWING;
        end else if (reg_req_in.wr) begin
            if (hit_thr)   thr_q    <= reg_req_in.wdata;
            if (hit_rsvd)  rsvd_q   <= reg_req_in.wdata;
            if (hit_sd)    sigdet_q <= reg_req_in.wdata;
            if (hit_idle)  idle_q   <= reg_req_in.wdata;
            if (hit_eq)    eq_q     <= reg_req_in.wdata;
            if (hit_swing) swing_q  <= reg_req_in.wdata;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            reg_rdata_out  <= lane_cond_pkg::READ_UNMAPPED;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rdata_out  <= reg_req_in.rd ? rmux : reg_rdata_out;
            reg_rvalid_out <= reg_req_in.rd;
        end
    end

    // ********************************************************************
    // Field decode to lane controls
    // ********************************************************************
    wire [1:0] tha_code  = thr_q[lane_cond_pkg::THR_ASSERT_LSB +: 2];
    wire [1:0] thd_code  = thr_q[lane_cond_pkg::THR_DEASSERT_LSB +: 2];
    wire       sd_off    = sigdet_q[lane_cond_pkg::SD_FORCE_OFF_BIT];
    wire       sd_on     = sigdet_q[lane_cond_pkg::SD_FORCE_ON_BIT];
    wire       idle_ovr  = idle_q[lane_cond_pkg::IDLE_OVR_BIT];
    wire       mute_sel  = idle_q[lane_cond_pkg::MUTE_SEL_BIT];
    wire [1:0] pres_mode = idle_q[lane_cond_pkg::PRES_MODE_LSB +: 2];
    wire [2:0] swing_cd  = swing_q[lane_cond_pkg::SWING_LSB +: 3];
    wire       auto_mode = (pres_mode == lane_cond_pkg::PRES_LIMITED) ||
                           (pres_mode == lane_cond_pkg::PRES_FOREVER);

    assign lane2_assert_mv_out   = lane_cond_pkg::ASSERT_MV[tha_code];
    assign lane2_deassert_mv_out = lane_cond_pkg::DEASSERT_MV[thd_code];
    // Off beats on when both are set, so a stuck lane can always be silenced
    assign lane3_sig_det_out = sd_off ? 1'b0 :
                               sd_on  ? 1'b1 :
                               lane3_sig_det_raw_in;
    assign lane3_mute_out = idle_ovr ? mute_sel : lane3_auto_idle_in;
    assign lane3_eq_level_out   = eq_q;
    assign lane3_short_prot_out = swing_q[lane_cond_pkg::SHORT_PROT_BIT];
    assign lane3_gen12_out      = swing_q[lane_cond_pkg::GEN_SEL_BIT];
    assign lane3_swing_code_out = swing_cd;
    assign lane3_swing_mv_out   = lane_cond_pkg::SWING_BASE_MV +
                                  11'(swing_cd * lane_cond_pkg::SWING_STEP_MV);

    // ********************************************************************
    // Presence-detect sequencer
    // ********************************************************************
    lane_cond_pkg::pd_state_type state_q;
    lane_cond_pkg::pd_state_type state_d;
    logic [TW-1:0] timer_q;
    logic [TW-1:0] timer_d;
    logic [AW-1:0] att_q;
    logic [AW-1:0] att_d;
    logic [1:0]    mode_prev_q;
    logic          probe_d;

    wire mode_change = pres_mode != mode_prev_q;
    wire tick        = timer_q == TIMER_LAST;
    wire limited     = pres_mode == lane_cond_pkg::PRES_LIMITED;

    always_comb begin
        state_d = state_q;
        timer_d = tick ? '0 : timer_q + TW'(1);
        att_d   = att_q;
        probe_d = 1'b0;
        if (mode_change) begin
            // A new mode restarts the attempt budget from zero
            state_d = auto_mode ? lane_cond_pkg::PD_PROBE : lane_cond_pkg::PD_OFF;
            timer_d = '0;
            att_d   = '0;
        end else begin
            case (state_q)
                lane_cond_pkg::PD_OFF: begin
                    timer_d = '0;
                end
                lane_cond_pkg::PD_PROBE: begin
                    if (lane3_receiver_seen_in && att_q != '0) begin
                        state_d = lane_cond_pkg::PD_FOUND;
                    end else if (tick && limited && att_q == ATT_LIMIT) begin
                        state_d = lane_cond_pkg::PD_GIVEUP;
                    end else if (tick) begin
                        probe_d = 1'b1;
                        att_d   = (att_q == ATT_LIMIT) ? att_q : att_q + AW'(1);
                    end
                end
                lane_cond_pkg::PD_FOUND: begin
                    timer_d = '0;
                end
                lane_cond_pkg::PD_GIVEUP: begin
                    timer_d = '0;
                end
                default: begin
                    state_d = lane_cond_pkg::PD_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_q         <= lane_cond_pkg::PD_OFF;
            timer_q         <= '0;
            att_q           <= '0;
            mode_prev_q     <= lane_cond_pkg::PRES_HIZ;
            lane3_probe_out <= 1'b0;
        end else begin
            state_q         <= state_d;
            timer_q         <= timer_d;
            att_q           <= att_d;
            mode_prev_q     <= pres_mode;
            lane3_probe_out <= probe_d;
        end
    end

    assign lane3_presence_found_out = state_q == lane_cond_pkg::PD_FOUND;
    assign lane3_term_50_out = (pres_mode == lane_cond_pkg::PRES_TERM) ||
                               (auto_mode && state_q == lane_cond_pkg::PD_FOUND);

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    sequence wr_swing;
        reg_req_in.wr && hit_swing;
    endsequence

    sequence wr_mute_on;
        reg_req_in.wr && hit_idle && reg_req_in.wdata[lane_cond_pkg::IDLE_OVR_BIT] &&
        reg_req_in.wdata[lane_cond_pkg::MUTE_SEL_BIT];
    endsequence

    a_assert_thr_210: assert property (reg_req_in.wr && hit_thr &&
        reg_req_in.wdata[3:2] == 2'h2 |=> lane2_assert_mv_out == 8'hD2)
        else $error("assert threshold not 210 mV");
    a_deassert_thr_150: assert property (reg_req_in.wr && hit_thr &&
        reg_req_in.wdata[1:0] == 2'h2 |=> lane2_deassert_mv_out == 8'h96)
        else $error("deassert threshold not 150 mV");
    a_force_off_wins: assert property (sd_off |-> !lane3_sig_det_out)
        else $error("signal detect active while forced off");
    a_force_on_holds: assert property (sd_on && !sd_off |-> lane3_sig_det_out)
        else $error("signal detect inactive while forced on");
    a_auto_idle_path: assert property (!idle_ovr |-> lane3_mute_out == lane3_auto_idle_in)
        else $error("mute not following automatic idle");
    a_mute_select_on: assert property (wr_mute_on |=> lane3_mute_out)
        else $error("mute select did not mute output");
    a_hiz_mode_term: assert property (pres_mode == lane_cond_pkg::PRES_HIZ
        |-> !lane3_term_50_out) else $error("termination on in hi-z mode");
    a_term_mode_now: assert property (reg_req_in.wr && hit_idle &&
        reg_req_in.wdata[3:2] == lane_cond_pkg::PRES_TERM |=> lane3_term_50_out)
        else $error("50 ohm not applied at once");
    a_probe_spacing: assert property (lane3_probe_out |-> $past(timer_q) == TIMER_LAST)
        else $error("probe not on period boundary");
    a_giveup_count: assert property (state_q == lane_cond_pkg::PD_GIVEUP
        |-> att_q == ATT_LIMIT && mode_prev_q == lane_cond_pkg::PRES_LIMITED)
        else $error("gave up at wrong count");
    a_auto_hiz_wait: assert property (auto_mode && !lane3_presence_found_out
        |-> !lane3_term_50_out) else $error("termination before detection");
    a_eq_reset_val: assert property ($past(rst_in) |-> eq_q == lane_cond_pkg::RST_L3_EQ &&
        swing_q == lane_cond_pkg::RST_L3_SWING) else $error("defaults not loaded at reset");
    a_thr_default: assert property ($past(rst_in)
        |-> lane2_assert_mv_out == lane_cond_pkg::ASSERT_MV[0] &&
        lane2_deassert_mv_out == lane_cond_pkg::DEASSERT_MV[0])
        else $error("thresholds not at default after reset");
    a_gen_select: assert property (wr_swing |=>
        lane3_gen12_out == $past(reg_req_in.wdata[6]) &&
        lane3_short_prot_out == $past(reg_req_in.wdata[7]))
        else $error("generation or protection bit not applied");
    a_swing_map: assert property (wr_swing and (reg_req_in.wdata[2:0] == 3'h7)
        |=> lane3_swing_mv_out == 11'h578) else $error("swing 111 not 1.4 V");

    // ********************************************************************
    // Sequencer checks
    // ********************************************************************
    // Idle cycles since the last probe; saturates so a parked lane never wraps
    logic [TW-1:0] since_probe_q;
    always_ff @(posedge mclk_in) begin
        if (rst_in || mode_change || lane3_probe_out) begin
            since_probe_q <= '0;
        end else if (since_probe_q != GAP_MAX) begin
            since_probe_q <= since_probe_q + TW'(1);
        end
    end

    // Answers only count once a probe has gone out
    sequence probe_answered;
        state_q == lane_cond_pkg::PD_PROBE && !mode_change &&
        lane3_receiver_seen_in && att_q != '0;
    endsequence

    sequence early_answer;
        state_q == lane_cond_pkg::PD_PROBE && !mode_change &&
        lane3_receiver_seen_in && att_q == '0;
    endsequence

    sequence gave_up;
        state_q == lane_cond_pkg::PD_GIVEUP && !mode_change;
    endsequence

    sequence fixed_mode;
        !auto_mode && !mode_change;
    endsequence

    a_found_on_answer: assert property (probe_answered
        |=> lane3_presence_found_out && (lane3_term_50_out || mode_change))
        else $error("answer did not reach found state");
    a_early_answer: assert property (early_answer
        |=> !lane3_presence_found_out)
        else $error("answer before first probe accepted");
    a_stop_after_limit: assert property (gave_up
        |=> !lane3_probe_out)
        else $error("probe after attempts ran out");
    a_forever_no_stop: assert property (
        pres_mode == lane_cond_pkg::PRES_FOREVER && !mode_change
        |-> state_q != lane_cond_pkg::PD_GIVEUP)
        else $error("unlimited mode gave up");
    a_restart_budget: assert property (mode_change
        |=> att_q == '0 && timer_q == '0)
        else $error("mode change did not restart count");
    a_attempt_cap: assert property (att_q <= ATT_LIMIT)
        else $error("attempt count past limit");
    a_probe_gap_max: assert property (
        state_q == lane_cond_pkg::PD_PROBE && since_probe_q == GAP_MAX
        |-> lane3_probe_out)
        else $error("probe period overrun");
    a_fixed_modes_idle: assert property (fixed_mode
        |-> state_q == lane_cond_pkg::PD_OFF && !lane3_probe_out)
        else $error("sequencer active in fixed mode");

    // ********************************************************************
    // Lane control and bus checks
    // ********************************************************************
    a_raw_detect_path: assert property (!sd_off && !sd_on
        |-> lane3_sig_det_out == lane3_sig_det_raw_in)
        else $error("signal detect not following raw level");
    a_mute_select_off: assert property (idle_ovr && !mute_sel
        |-> !lane3_mute_out)
        else $error("output muted with mute select clear");
    a_eq_write_lands: assert property (reg_req_in.wr && hit_eq
        |=> lane3_eq_level_out == $past(reg_req_in.wdata))
        else $error("equalizer write not applied");
    a_read_returns: assert property (reg_req_in.rd
        |=> reg_rvalid_out && reg_rdata_out == $past(rmux))
        else $error("read data not returned");
    a_idle_read_quiet: assert property (!reg_req_in.rd
        |=> !reg_rvalid_out)
        else $error("read pulse without request");

endmodule : lane_signal_conditioning_regs

// [tb/receiver_model.sv]
// Far-end receiver model that answers presence probes
`timescale 1ns/1ps
module receiver_model (
    input  wire logic       mclk_in,
    input  wire logic       clr_in,
    input  wire logic       probe_in,
    input  wire logic [7:0] answer_after_in,
    output logic            seen_out,
    output logic [7:0]      probe_count_out,
    output logic [7:0]      probe_gap_out
);
    // ****************************************************************
    // Probe counting and answer
    // ****************************************************************
    logic [7:0] since_q;
    // Answer is a held level; zero answer count means no receiver at all
    always_ff @(posedge mclk_in) begin
        if (clr_in) begin
            seen_out <= 1'b0;
            probe_count_out <= 8'h00;
            probe_gap_out <= 8'h00;
            since_q <= 8'h00;
        end else if (probe_in) begin
            probe_count_out <= probe_count_out + 8'h01;
            probe_gap_out <= since_q + 8'h01;
            since_q <= 8'h00;
            seen_out <= (answer_after_in != 8'h00) && (probe_count_out + 8'h01 >= answer_after_in);
        end else begin
            since_q <= since_q + 8'h01;
        end
    end
endmodule : receiver_model

// [tb/tb_top.sv]
// Self-checking testbench for the lane conditioning register bank
`timescale 1ns/1ps
module tb_top;
    // ****************************************************************
    // Signals, design and partner
    // ****************************************************************
    localparam int PERIOD = 8;
    localparam int TRIES  = 3;
    typedef struct packed {
        logic [7:0] addr; logic [7:0] data; logic raw; logic idle;
        logic [10:0] exp_a; logic [10:0] exp_b;
    } row_type;
    logic mclk_in, rst_in, raw, idle, rx_clr, seen;
    lane_cond_pkg::reg_req_type req;
    logic [7:0] reg_rdata_out, a_mv, d_mv, eq, rx_ans, cnt, gap;
    logic [2:0] code;
    logic [10:0] mv;
    logic rvalid, sd, mute, probe, term, found, prot, gen12;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    lane_signal_conditioning_regs #(.PROBE_CYCLES(PERIOD), .PROBE_ATTEMPTS(TRIES)) DUT (
        .mclk_in(mclk_in), .rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(rvalid), .lane2_assert_mv_out(a_mv), .lane2_deassert_mv_out(d_mv),
        .lane3_sig_det_raw_in(raw), .lane3_sig_det_out(sd), .lane3_auto_idle_in(idle),
        .lane3_mute_out(mute), .lane3_receiver_seen_in(seen), .lane3_probe_out(probe),
        .lane3_term_50_out(term), .lane3_presence_found_out(found),
        .lane3_eq_level_out(eq), .lane3_short_prot_out(prot), .lane3_gen12_out(gen12),
        .lane3_swing_code_out(code), .lane3_swing_mv_out(mv));
    receiver_model rx (.mclk_in(mclk_in), .clr_in(rx_clr), .probe_in(probe),
        .answer_after_in(rx_ans), .seen_out(seen), .probe_count_out(cnt), .probe_gap_out(gap));
    // Ordinary cases: register, value, raw detect, auto idle, two expected outputs
    row_type rows [23] = '{
        '{8'h20, 8'h00, 1'b0, 1'b0, 11'h0B4, 11'h06E}, '{8'h20, 8'h05, 1'b0, 1'b0, 11'h0A0, 11'h064},
        '{8'h20, 8'h0A, 1'b0, 1'b0, 11'h0D2, 11'h096}, '{8'h20, 8'h0F, 1'b0, 1'b0, 11'h0BE, 11'h082},
        '{8'h21, 8'h5A, 1'b0, 1'b0, 11'h000, 11'h000}, '{8'h22, 8'h00, 1'b1, 1'b0, 11'h001, 11'h000},
        '{8'h22, 8'h00, 1'b0, 1'b0, 11'h000, 11'h000}, '{8'h22, 8'h02, 1'b0, 1'b0, 11'h001, 11'h000},
        '{8'h22, 8'h04, 1'b1, 1'b0, 11'h000, 11'h000}, '{8'h22, 8'h06, 1'b1, 1'b0, 11'h000, 11'h000},
        '{8'h23, 8'h00, 1'b0, 1'b1, 11'h001, 11'h000}, '{8'h23, 8'h00, 1'b0, 1'b0, 11'h000, 11'h000},
        '{8'h23, 8'h20, 1'b0, 1'b1, 11'h000, 11'h000}, '{8'h23, 8'h30, 1'b0, 1'b0, 11'h001, 11'h000},
        '{8'h23, 8'h10, 1'b0, 1'b0, 11'h000, 11'h000}, '{8'h24, 8'h55, 1'b0, 1'b0, 11'h055, 11'h000},
        '{8'h24, 8'hFF, 1'b0, 1'b0, 11'h0FF, 11'h000}, '{8'h25, 8'h28, 1'b0, 1'b0, 11'h2BC, 11'h000},
        '{8'h25, 8'h6F, 1'b0, 1'b0, 11'h578, 11'h00F}, '{8'h25, 8'hAB, 1'b0, 1'b0, 11'h3E8, 11'h013},
        '{8'h25, 8'hAD, 1'b0, 1'b0, 11'h4B0, 11'h015}, '{8'h25, 8'hE9, 1'b0, 1'b0, 11'h320, 11'h019},
        '{8'h30, 8'h77, 1'b0, 1'b0, 11'h000, 11'h000}};
    logic [7:0] dflt [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h2F, 8'hAD};
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    function automatic logic [21:0] seen_ab(input logic [7:0] a);
        case (a)
            8'h20: seen_ab = {3'h0, a_mv, 3'h0, d_mv};
            8'h22: seen_ab = {10'h000, sd, 11'h000};
            8'h23: seen_ab = {10'h000, mute, 10'h000, term};
            8'h24: seen_ab = {3'h0, eq, 11'h000};
            8'h25: seen_ab = {mv, 6'h00, prot, gen12, code};
            default: seen_ab = 22'h00_0000;
        endcase
    endfunction : seen_ab
    task automatic chk(input string what, input logic [21:0] got, input logic [21:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk_in);
        req <= '0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk_in);
        req <= '0;
        #1;
        chk("read data", {13'h0000, rvalid, reg_rdata_out}, {13'h0000, 1'b1, exp});
        @(posedge mclk_in);
        #1;
        chk("read pulse", {21'h00_0000, rvalid}, 22'h00_0000);
    endtask : reg_read
    task automatic check_defaults();
        for (int k = 0; k < 6; k++) reg_read(8'(8'h20 + k), dflt[k]);
        chk("reset lane two", seen_ab(8'h20), 22'h05_A06E);
        chk("reset swing", seen_ab(8'h25), {11'h4B0, 11'h015});
        chk("reset presence", {20'h0_0000, term, found}, 22'h00_0000);
    endtask : check_defaults
    task automatic run_mode(input logic [7:0] d, input logic [7:0] ans, input int cycles);
        @(posedge mclk_in);
        rx_ans <= ans;
        rx_clr <= 1'b1;
        reg_write(8'h23, 8'h00);
        rx_clr <= 1'b0;
        reg_write(8'h23, d);
        repeat (cycles) @(posedge mclk_in);
        #1;
    endtask : run_mode
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    // Whole run needs well under a thousand cycles
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            give_verdict();
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst_in = 1'b1;
        req = '0;
        raw = 1'b0;
        idle = 1'b0;
        rx_clr = 1'b1;
        rx_ans = 8'h00;
        repeat (10) @(posedge mclk_in);
        rst_in <= 1'b0;
        check_defaults();
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge mclk_in);
            raw <= rows[i].raw;
            idle <= rows[i].idle;
            reg_write(rows[i].addr, rows[i].data);
            @(posedge mclk_in);
            #1;
            chk("lane outputs", seen_ab(rows[i].addr), {rows[i].exp_a, rows[i].exp_b});
            reg_read(rows[i].addr, (rows[i].addr == 8'h30) ? 8'h00 : rows[i].data);
        end
        $display("test rows done");
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        check_defaults();
        $display("test mid-run reset done");
        run_mode(8'h0C, 8'h00, 20);
        chk("mode 11", {12'h000, term, found, cnt}, {12'h000, 1'b1, 1'b0, 8'h00});
        run_mode(8'h04, 8'h00, 60);
        chk("mode 01", {4'h0, term, found, cnt, gap}, {6'h00, 8'(TRIES), 8'(PERIOD)});
        run_mode(8'h08, 8'h05, 70);
        chk("mode 10", {4'h0, term, found, cnt, gap}, {6'h03, 8'h05, 8'(PERIOD)});
        run_mode(8'h04, 8'h02, 40);
        chk("mode 01 found", {4'h0, term, found, cnt, gap}, {6'h03, 8'h02, 8'(PERIOD)});
        $display("test presence done");
        give_verdict();
    end
endmodule : tb_top
